// ==== rtl/loaddump_alarm_monitor.sv ====
// load-dump alarm qualification with register port
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ldm_cfg.svh"
// Overview of operation
// [R1] voltage imbalance alarm after any phase deviates past limit for voltage-fail time
// [R2] current imbalance alarm, same limit and same voltage-fail time
// [R3] imbalance checks held off until engine runs and hold-off time elapsed
// [R4] current imbalance and overcurrent actions chosen by configuration
// [R5] overcurrent alarm when a phase exceeds limit longer than curve allows
// [R6] larger overcurrent excess gives shorter allowed time
// [R7] all phases back under limit cancels the overcurrent timer
// [R8] overload alarm when power stays above limit for overload time
// [R9] reverse power alarm when negative power exceeds limit for its time
// [R10] phase order alarm only when enabled and rotation reversed
// [R11] breaker fault when feedback missing at breaker timer expiry
// [R12] breaker faults only with a feedback input defined
// [R13] speed lost alarm when pickup speed below crank speed for qualify time
// [R14] speed lost action chosen by configuration
// [R15] service alarm while any service counter expired
// [R16] both keys held five seconds clear service counters, show completion
// [R17] unit locked alarm while remotely locked
// [R18] unresolved wiring alarm when auto detect on and none found after hold-off
// [R19] load dump opens generator breaker, engine keeps running
// [R20] timers restart when condition drops; each alarm is its own flag
module loaddump_alarm_monitor
#(
  parameter int TICK_CYCLES = `LDM_TICK_CYCLES
)
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // register port
  input  wire logic        [3:0]  regAddr,
  input  wire logic        [15:0] regWrData,
  input  wire logic               regWrStb,
  input  wire logic               regRdStb,
  output logic             [15:0] regRdData,
  // measurements
  input  wire logic        [15:0] voltPhA,
  input  wire logic        [15:0] voltPhB,
  input  wire logic        [15:0] voltPhC,
  input  wire logic        [15:0] currPhA,
  input  wire logic        [15:0] currPhB,
  input  wire logic        [15:0] currPhC,
  input  wire logic signed [15:0] activePower,
  input  wire logic               rotationReversed,
  input  wire logic        [15:0] pickupRpm,
  input  wire logic               topologyFound,
  input  wire logic        [1:0]  serviceExpired,
  // breaker commands
  input  wire logic               utilityOpenCmd,
  input  wire logic               generatorCloseCmd,
  // pins
  input  wire logic               engineRunPin,
  input  wire logic               utilityOpenFbPin,
  input  wire logic               generatorClosedFbPin,
  input  wire logic               remoteLockPin,
  input  wire logic               keyMutePin,
  input  wire logic               keyLampPin,
  // alarms and actions
  output logic             [11:0] alarmFlags,
  output logic                    genBreakerOpenReq,
  output logic                    warningReq,
  output logic                    shutdownReq,
  output logic                    serviceCounterClear,
  output logic                    showCompleted
);
  // ----------------------------------------
  // registers and synchronised pins
  // ----------------------------------------
  logic [15:0] ctrlReg;
  logic [15:0] imbLimitReg;
  logic [15:0] ocLimitReg;
  logic [15:0] olLimitReg;
  logic [15:0] rpLimitReg;
  logic [15:0] crankRpmReg;
  logic [15:0] voltFailTimeReg;
  logic [15:0] overloadTimeReg;
  logic [15:0] reverseTimeReg;
  logic [15:0] breakerTimeReg;
  logic [15:0] speedLossQualifyTimeReg;
  logic [15:0] holdOffTimeReg;
  logic [15:0] ocCurveReg;
  logic [5:0]  pinSync;
  logic        runS;
  logic        utilFbS;
  logic        genFbS;
  logic        lockS;
  logic        keyMuteS;
  logic        keyLampS;

  input_sync #(.W(6)) uSync
  (
    .core_clk (core_clk),
    .srst     (srst),
    .pinIn    ({keyLampPin, keyMutePin, remoteLockPin,
                generatorClosedFbPin, utilityOpenFbPin, engineRunPin}),
    .syncOut  (pinSync)
  );
  assign runS     = pinSync[0];
  assign utilFbS  = pinSync[1];
  assign genFbS   = pinSync[2];
  assign lockS    = pinSync[3];
  assign keyMuteS = pinSync[4];
  assign keyLampS = pinSync[5];

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  logic [31:0] tickCntReg;
  logic        msTick;
  assign msTick = (tickCntReg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (srst || msTick)
      tickCntReg <= 32'h0000_0000;
    else
      tickCntReg <= tickCntReg + 32'h0000_0001;
  end

  // ----------------------------------------
  // phase comparisons
  // ----------------------------------------
  logic [15:0] voltArr [3];
  logic [15:0] currArr [3];
  logic [15:0] ocExcess [3];
  logic [17:0] voltSum;
  logic [17:0] currSum;
  logic [17:0] imbLim3;
  logic [2:0]  voltDev;
  logic [2:0]  currDev;
  logic [2:0]  ocOver;
  logic [15:0] ocMax;

  assign voltArr[0] = voltPhA;
  assign voltArr[1] = voltPhB;
  assign voltArr[2] = voltPhC;
  assign currArr[0] = currPhA;
  assign currArr[1] = currPhB;
  assign currArr[2] = currPhC;
  assign voltSum = {2'b00, voltPhA} + {2'b00, voltPhB} + {2'b00, voltPhC};
  assign currSum = {2'b00, currPhA} + {2'b00, currPhB} + {2'b00, currPhC};
  assign imbLim3 = {2'b00, imbLimitReg} + {1'b0, imbLimitReg, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gPhase
      logic [17:0] v3;
      logic [17:0] i3;
      assign v3 = {2'b00, voltArr[g]} + {1'b0, voltArr[g], 1'b0};
      assign i3 = {2'b00, currArr[g]} + {1'b0, currArr[g], 1'b0};
      assign voltDev[g] = ((v3 > voltSum) ? v3 - voltSum : voltSum - v3) > imbLim3; // [R1]
      assign currDev[g] = ((i3 > currSum) ? i3 - currSum : currSum - i3) > imbLim3; // [R2]
      assign ocOver[g] = currArr[g] > ocLimitReg; // [R5]
      assign ocExcess[g] = ocOver[g] ? currArr[g] - ocLimitReg : 16'h0000;
    end
  endgenerate

  always_comb
  begin
    ocMax = ocExcess[0];
    if (ocExcess[1] > ocMax)
      ocMax = ocExcess[1];
    if (ocExcess[2] > ocMax)
      ocMax = ocExcess[2];
  end

  // ----------------------------------------
  // overcurrent inverse-time accumulator
  // ----------------------------------------
  logic [31:0] ocAccReg;
  logic        ocDone;
  assign ocDone = ocAccReg >= {8'h00, ocCurveReg, 8'h00};

  always_ff @(posedge core_clk)
  begin
    if (srst || ocOver == 3'b000)
      ocAccReg <= 32'h0000_0000; // [R7]
    else if (msTick && !ocDone)
      ocAccReg <= ocAccReg + {16'h0000, ocMax}; // [R6]
  end

  // ----------------------------------------
  // qualification timers
  // ----------------------------------------
  logic signed [16:0] pw17;
  logic armed;
  logic olCond;
  logic rpCond;
  logic ubCond;
  logic gbCond;
  logic spCond;
  logic vImbExp;
  logic cImbExp;
  logic olExp;
  logic rpExp;
  logic utilityBreakerOpenFault;
  logic generatorBreakerCloseFault;
  logic spExp;
  logic wiringSchemeUnresolvedAlarm;

  assign pw17   = {activePower[15], activePower};
  assign olCond = pw17 > $signed({1'b0, olLimitReg}); // [R8]
  assign rpCond = activePower[15] && ((-pw17) > $signed({1'b0, rpLimitReg})); // [R9]
  assign ubCond = ctrlReg[`LDM_CTL_UFB] && utilityOpenCmd && !utilFbS; // [R11] [R12]
  assign gbCond = ctrlReg[`LDM_CTL_GFB] && generatorCloseCmd && !genFbS; // [R11] [R12]
  assign spCond = runS && (pickupRpm < crankRpmReg); // [R13]

  qual_timer uHold (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(runS), .limit(holdOffTimeReg), .expired(armed)); // [R3]
  qual_timer uVImb (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(armed && (|voltDev)), .limit(voltFailTimeReg), .expired(vImbExp)); // [R1]
  qual_timer uCImb (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(armed && (|currDev)), .limit(voltFailTimeReg), .expired(cImbExp)); // [R2]
  qual_timer uOvl  (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(olCond), .limit(overloadTimeReg), .expired(olExp));
  qual_timer uRev  (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(rpCond), .limit(reverseTimeReg), .expired(rpExp));
  qual_timer uUBrk (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(ubCond), .limit(breakerTimeReg), .expired(utilityBreakerOpenFault));
  qual_timer uGBrk (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(gbCond), .limit(breakerTimeReg), .expired(generatorBreakerCloseFault));
  qual_timer uSpd  (.core_clk(core_clk), .srst(srst), .tick(msTick),
                    .cond(spCond), .limit(speedLossQualifyTimeReg), .expired(spExp));

  assign wiringSchemeUnresolvedAlarm = ctrlReg[`LDM_CTL_TOPO] && armed && !topologyFound; // [R18]

  // ----------------------------------------
  // sticky alarm flags
  // ----------------------------------------
  logic [11:0] alarmEvt;
  logic [11:0] flagClr;

  assign alarmEvt[`LDM_AL_VIMB] = vImbExp;
  assign alarmEvt[`LDM_AL_CIMB] = cImbExp;
  assign alarmEvt[`LDM_AL_OC]   = ocDone && (ocOver != 3'b000); // [R5]
  assign alarmEvt[`LDM_AL_OVL]  = olExp;
  assign alarmEvt[`LDM_AL_REV]  = rpExp;
  assign alarmEvt[`LDM_AL_SEQ]  = ctrlReg[`LDM_CTL_SEQ] && rotationReversed; // [R10]
  assign alarmEvt[`LDM_AL_UBRK] = utilityBreakerOpenFault;
  assign alarmEvt[`LDM_AL_GBRK] = generatorBreakerCloseFault;
  assign alarmEvt[`LDM_AL_SPD]  = spExp;
  assign alarmEvt[`LDM_AL_SVC]  = |serviceExpired; // [R15]
  assign alarmEvt[`LDM_AL_LOCK] = lockS; // [R17]
  assign alarmEvt[`LDM_AL_TOPO] = wiringSchemeUnresolvedAlarm;
  assign flagClr = (regWrStb && regAddr == `LDM_REG_FLAGS) ? regWrData[11:0] : 12'h000;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      alarmFlags <= 12'h000;
    else
      alarmFlags <= alarmEvt | (alarmFlags & ~flagClr); // [R20]
  end

  // ----------------------------------------
  // action routing
  // ----------------------------------------
  ldm_pkg::action_t alarmAct [12];
  logic [11:0] ldHit;
  logic [11:0] warnHit;
  logic [11:0] shutHit;

  genvar h;
  generate
    for (h = 0; h < 12; h++)
    begin : gAct
      if (h == `LDM_AL_CIMB)
      begin : gCi
        assign alarmAct[h] = ldm_pkg::action_t'(ctrlReg[`LDM_CTL_CIACT +: 2]); // [R4]
      end
      else if (h == `LDM_AL_OC)
      begin : gOc
        assign alarmAct[h] = ldm_pkg::action_t'(ctrlReg[`LDM_CTL_OCACT +: 2]); // [R4]
      end
      else if (h == `LDM_AL_SPD)
      begin : gSp
        assign alarmAct[h] = ldm_pkg::action_t'(ctrlReg[`LDM_CTL_SPACT +: 2]); // [R14]
      end
      else
      begin : gLd
        assign alarmAct[h] = ldm_pkg::ACT_LDUMP;
      end
      assign ldHit[h]   = alarmFlags[h] && (alarmAct[h] == ldm_pkg::ACT_LDUMP);
      assign warnHit[h] = alarmFlags[h] && (alarmAct[h] == ldm_pkg::ACT_WARN);
      assign shutHit[h] = alarmFlags[h] && (alarmAct[h] == ldm_pkg::ACT_SHUT);
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      genBreakerOpenReq <= 1'b0;
      warningReq        <= 1'b0;
      shutdownReq       <= 1'b0;
    end
    else
    begin
      genBreakerOpenReq <= |ldHit; // [R19]
      warningReq        <= |warnHit;
      shutdownReq       <= |shutHit;
    end
  end

  // ----------------------------------------
  // service reset key hold
  // ----------------------------------------
  ldm_pkg::key_state_t keyStateReg;
  logic [15:0] keyCntReg;
  logic        keysBoth;
  assign keysBoth = keyMuteS && keyLampS;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      keyStateReg         <= ldm_pkg::KEY_IDLE;
      keyCntReg           <= 16'h0000;
      serviceCounterClear <= 1'b0;
      showCompleted       <= 1'b0;
    end
    else
    begin
      serviceCounterClear <= 1'b0;
      showCompleted       <= 1'b0;
      case (keyStateReg)
        ldm_pkg::KEY_IDLE:
        begin
          keyCntReg <= 16'h0000;
          if (keysBoth)
            keyStateReg <= ldm_pkg::KEY_HOLD;
        end
        ldm_pkg::KEY_HOLD:
        begin
          if (!keysBoth)
            keyStateReg <= ldm_pkg::KEY_IDLE;
          else if (keyCntReg == 16'(`LDM_KEY_HOLD_TICKS))
          begin
            serviceCounterClear <= 1'b1; // [R16]
            showCompleted       <= 1'b1;
            keyStateReg         <= ldm_pkg::KEY_DONE;
          end
          else if (msTick)
            keyCntReg <= keyCntReg + 16'h0001;
        end
        ldm_pkg::KEY_DONE:
        begin
          if (!keysBoth)
            keyStateReg <= ldm_pkg::KEY_IDLE;
        end
        default:
          keyStateReg <= ldm_pkg::KEY_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // register write and read
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrlReg                 <= `LDM_RST_CTRL;
      imbLimitReg             <= `LDM_RST_LIM;
      ocLimitReg              <= `LDM_RST_LIM;
      olLimitReg              <= `LDM_RST_LIM;
      rpLimitReg              <= `LDM_RST_LIM;
      crankRpmReg             <= 16'h0000;
      voltFailTimeReg         <= `LDM_RST_TIME;
      overloadTimeReg         <= `LDM_RST_TIME;
      reverseTimeReg          <= `LDM_RST_TIME;
      breakerTimeReg          <= `LDM_RST_TIME;
      speedLossQualifyTimeReg <= `LDM_RST_TIME;
      holdOffTimeReg          <= `LDM_RST_TIME;
      ocCurveReg              <= `LDM_RST_OCK;
    end
    else if (regWrStb)
    begin
      case (regAddr)
        `LDM_REG_CTRL:  ctrlReg                 <= regWrData;
        `LDM_REG_IMB:   imbLimitReg             <= regWrData;
        `LDM_REG_OCLIM: ocLimitReg              <= regWrData;
        `LDM_REG_OLLIM: olLimitReg              <= regWrData;
        `LDM_REG_RPLIM: rpLimitReg              <= regWrData;
        `LDM_REG_CRANK: crankRpmReg             <= regWrData;
        `LDM_REG_VFT:   voltFailTimeReg         <= regWrData;
        `LDM_REG_OLT:   overloadTimeReg         <= regWrData;
        `LDM_REG_RPT:   reverseTimeReg          <= regWrData;
        `LDM_REG_CBT:   breakerTimeReg          <= regWrData;
        `LDM_REG_SPT:   speedLossQualifyTimeReg <= regWrData;
        `LDM_REG_HOT:   holdOffTimeReg          <= regWrData;
        `LDM_REG_OCK:   ocCurveReg              <= regWrData;
        default:        ctrlReg                 <= ctrlReg;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || !regRdStb)
      regRdData <= 16'h0000;
    else
    begin
      case (regAddr)
        `LDM_REG_CTRL:  regRdData <= ctrlReg;
        `LDM_REG_IMB:   regRdData <= imbLimitReg;
        `LDM_REG_OCLIM: regRdData <= ocLimitReg;
        `LDM_REG_OLLIM: regRdData <= olLimitReg;
        `LDM_REG_RPLIM: regRdData <= rpLimitReg;
        `LDM_REG_CRANK: regRdData <= crankRpmReg;
        `LDM_REG_VFT:   regRdData <= voltFailTimeReg;
        `LDM_REG_OLT:   regRdData <= overloadTimeReg;
        `LDM_REG_RPT:   regRdData <= reverseTimeReg;
        `LDM_REG_CBT:   regRdData <= breakerTimeReg;
        `LDM_REG_SPT:   regRdData <= speedLossQualifyTimeReg;
        `LDM_REG_HOT:   regRdData <= holdOffTimeReg;
        `LDM_REG_OCK:   regRdData <= ocCurveReg;
        `LDM_REG_FLAGS: regRdData <= {4'h0, alarmFlags};
        `LDM_REG_LIVE:  regRdData <= {9'h000, keyLampS, keyMuteS, lockS, genFbS, utilFbS, runS, armed};
        default:        regRdData <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_imb_gated : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    (alarmEvt[`LDM_AL_VIMB] || alarmEvt[`LDM_AL_CIMB]) |-> armed && runS)
    else $error("imbalance set before hold-off");
  a_oc_cancel : assert property (@(posedge core_clk) disable iff (srst) // [R7]
    (ocOver == 3'b000) |=> (ocAccReg == 32'h0000_0000) && !alarmEvt[`LDM_AL_OC])
    else $error("overcurrent timer not cancelled");
  a_oc_rate : assert property (@(posedge core_clk) disable iff (srst) // [R6]
    (msTick && !ocDone && ocOver != 3'b000 && $stable(ocOver))
      |=> ocAccReg == $past(ocAccReg) + {16'h0000, $past(ocMax)})
    else $error("overcurrent accumulation wrong");
  a_power_cond : assert property (@(posedge core_clk) disable iff (srst) // [R9]
    alarmEvt[`LDM_AL_REV] |-> activePower[15] && !alarmEvt[`LDM_AL_OVL])
    else $error("reverse power without negative power");
  a_seq_enable : assert property (@(posedge core_clk) disable iff (srst) // [R10]
    !ctrlReg[`LDM_CTL_SEQ] |-> !alarmEvt[`LDM_AL_SEQ])
    else $error("phase order alarm while disabled");
  a_brk_defined : assert property (@(posedge core_clk) disable iff (srst) // [R12]
    (!ctrlReg[`LDM_CTL_UFB] |-> !alarmEvt[`LDM_AL_UBRK]) and
    (!ctrlReg[`LDM_CTL_GFB] |-> !alarmEvt[`LDM_AL_GBRK]))
    else $error("breaker fault without feedback input");
  a_svc_clear : assert property (@(posedge core_clk) disable iff (srst) // [R16]
    serviceCounterClear |-> showCompleted && $past(keysBoth, 2) ##1 !serviceCounterClear)
    else $error("service clear pulse wrong");
  a_lock_flag : assert property (@(posedge core_clk) disable iff (srst) // [R17]
    lockS |=> alarmFlags[`LDM_AL_LOCK] [*2])
    else $error("lock flag not held");
  a_ld_output : assert property (@(posedge core_clk) disable iff (srst) // [R19]
    (alarmFlags[`LDM_AL_OVL] && !flagClr[`LDM_AL_OVL]) |=> ##1 genBreakerOpenReq)
    else $error("load dump not requested");
  a_act_select : assert property (@(posedge core_clk) disable iff (srst) // [R4]
    (alarmFlags[`LDM_AL_OC] && ctrlReg[`LDM_CTL_OCACT +: 2] == 2'b11 && $stable(ctrlReg)) |=> shutdownReq)
    else $error("overcurrent action not applied");
  a_spd_cond : assert property (@(posedge core_clk) disable iff (srst) // [R13]
    alarmEvt[`LDM_AL_SPD] |-> pickupRpm < crankRpmReg)
    else $error("speed lost with speed above crank");
endmodule
`default_nettype wire

// ==== rtl/ldm_cfg.svh ====
// register map, field positions, reset values and timing counts
`ifndef LDM_CFG_SVH
`define LDM_CFG_SVH
// register indices
`define LDM_REG_CTRL  4'h0
`define LDM_REG_IMB   4'h1
`define LDM_REG_OCLIM 4'h2
`define LDM_REG_OLLIM 4'h3
`define LDM_REG_RPLIM 4'h4
`define LDM_REG_CRANK 4'h5
`define LDM_REG_VFT   4'h6
`define LDM_REG_OLT   4'h7
`define LDM_REG_RPT   4'h8
`define LDM_REG_CBT   4'h9
`define LDM_REG_SPT   4'ha
`define LDM_REG_HOT   4'hb
`define LDM_REG_OCK   4'hc
`define LDM_REG_FLAGS 4'hd
`define LDM_REG_LIVE  4'he
// control bits
`define LDM_CTL_SEQ   0
`define LDM_CTL_UFB   1
`define LDM_CTL_GFB   2
`define LDM_CTL_TOPO  3
`define LDM_CTL_CIACT 4
`define LDM_CTL_OCACT 6
`define LDM_CTL_SPACT 8
// alarm flag bits
`define LDM_AL_VIMB 0
`define LDM_AL_CIMB 1
`define LDM_AL_OC   2
`define LDM_AL_OVL  3
`define LDM_AL_REV  4
`define LDM_AL_SEQ  5
`define LDM_AL_UBRK 6
`define LDM_AL_GBRK 7
`define LDM_AL_SPD  8
`define LDM_AL_SVC  9
`define LDM_AL_LOCK 10
`define LDM_AL_TOPO 11
// reset values
`define LDM_RST_CTRL 16'h02a0
`define LDM_RST_LIM  16'h7fff
`define LDM_RST_TIME 16'h03e8
`define LDM_RST_OCK  16'h0400
// timing
`define LDM_CLK_NS         4
`define LDM_TICK_NS        1000000
`define LDM_TICK_CYCLES    (`LDM_TICK_NS / `LDM_CLK_NS)
`define LDM_KEY_HOLD_S     5
`define LDM_KEY_HOLD_TICKS (`LDM_KEY_HOLD_S * (1000000000 / `LDM_TICK_NS))
`endif

// ==== rtl/ldm_pkg.sv ====
// shared types of the load-dump alarm block
`default_nettype none
package ldm_pkg;
  typedef enum logic [1:0]
  {
    ACT_NONE  = 2'b00,
    ACT_WARN  = 2'b01,
    ACT_LDUMP = 2'b10,
    ACT_SHUT  = 2'b11
  } action_t;
  typedef enum logic [1:0]
  {
    KEY_IDLE = 2'b00,
    KEY_HOLD = 2'b01,
    KEY_DONE = 2'b10
  } key_state_t;
endpackage
`default_nettype wire

// ==== rtl/input_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module input_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // pins and result
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1Reg   <= '0;
      s2Reg   <= '0;
      s3Reg   <= '0;
      syncOut <= '0;
    end
    else
    begin
      s1Reg   <= pinIn;
      s2Reg   <= s1Reg;
      s3Reg   <= s2Reg;
      syncOut <= (s2Reg & ~(s2Reg ^ s3Reg)) | (syncOut & (s2Reg ^ s3Reg));
    end
  end
endmodule
`default_nettype wire

// ==== rtl/qual_timer.sv ====
// millisecond qualification timer, restarts when its condition drops
`timescale 1ns/1ps
`default_nettype none
module qual_timer
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // timing
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [15:0] limit,
  // result
  output logic             expired
);
  logic [15:0] cntReg;

  assign expired = cond && (cntReg >= limit);

  always_ff @(posedge core_clk)
  begin
    if (srst || !cond)
      cntReg <= 16'h0000; // [R20]
    else if (tick && cntReg < limit)
      cntReg <= cntReg + 16'h0001;
  end

  a_timer_restart : assert property (@(posedge core_clk) disable iff (srst) // [R20]
    !cond |=> (cntReg == 16'h0000) && !expired)
    else $error("timer did not restart");
endmodule
`default_nettype wire

// ==== sim/ldm_far_side.sv ====
// far-side model: breaker contacts and front keys
`timescale 1ns/1ps
`default_nettype none
module ldm_far_side
(
  // clock and bench controls
  input  wire logic core_clk,
  input  wire logic stuck,
  input  wire logic keyReq,
  // breaker commands
  input  wire logic utilityOpenCmd,
  input  wire logic generatorCloseCmd,
  // contacts and keys
  output logic      utilityOpenFbPin,
  output logic      generatorClosedFbPin,
  output logic      keyMutePin,
  output logic      keyLampPin
);
  logic [2:0] uDly = 3'h0;
  logic [2:0] gDly = 3'h0;
  // contacts follow the command after travel time unless stuck
  always @(posedge core_clk)
  begin
    uDly <= {uDly[1:0], utilityOpenCmd & ~stuck};
    gDly <= {gDly[1:0], generatorCloseCmd & ~stuck};
  end
  assign utilityOpenFbPin     = uDly[2];
  assign generatorClosedFbPin = gDly[2];
  assign keyMutePin           = keyReq;
  assign keyLampPin           = keyReq;
endmodule
`default_nettype wire

// ==== sim/loaddump_alarm_monitor_tb_top.sv ====
// self-checking bench of the load-dump alarm monitor
`timescale 1ns/1ps
`default_nettype none
module loaddump_alarm_monitor_tb_top;
  typedef struct {logic [2:0] f; logic [15:0] v; logic [11:0] e;} row_t;
  logic core_clk = 1'b0, srst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, stuck = 1'b0, keyReq = 1'b0;
  logic rotationReversed = 1'b0, topologyFound = 1'b1, utilityOpenCmd = 1'b0, generatorCloseCmd = 1'b0;
  logic engineRunPin = 1'b0, remoteLockPin = 1'b0;
  logic [1:0] serviceExpired = 2'h0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, voltPhA = 16'h00e6, voltPhB = 16'h00e6, voltPhC = 16'h00e6;
  logic [15:0] currPhA = 16'h0032, currPhB = 16'h0032, currPhC = 16'h0032, pickupRpm = 16'h05dc;
  logic signed [15:0] activePower = 16'h01f4;
  logic [15:0] regRdData;
  logic [11:0] alarmFlags;
  logic genBreakerOpenReq, warningReq, shutdownReq, serviceCounterClear, showCompleted;
  logic utilityOpenFbPin, generatorClosedFbPin, keyMutePin, keyLampPin;
  logic [5:0] misc;
  int mismatches = 0, nChecks = 0, k;
  logic [15:0] cfg [13] = '{16'h02af, 16'h000a, 16'h0064, 16'h03e8, 16'h0064, 16'h0032, 16'h0002,
    16'h0002, 16'h0002, 16'h000a, 16'h0002, 16'h0002, 16'h0001};
  row_t rows [13] = '{'{3'h0, 16'h0000, 12'h000}, '{3'h5, 16'h0008, 12'h000}, '{3'h1, 16'h012c, 12'h001},
    '{3'h2, 16'h0050, 12'h002}, '{3'h2, 16'h00c8, 12'h006}, '{3'h3, 16'h07d0, 12'h008},
    '{3'h3, 16'hfe0c, 12'h010}, '{3'h5, 16'h0001, 12'h020}, '{3'h5, 16'h0018, 12'h0c0},
    '{3'h4, 16'h0000, 12'h100}, '{3'h5, 16'h0004, 12'h200}, '{3'h5, 16'h0002, 12'h400},
    '{3'h5, 16'h0020, 12'h800}};
  always #2 core_clk = ~core_clk;
  loaddump_alarm_monitor #(.TICK_CYCLES(4)) loaddump_alarm_monitor_inst (.*);
  ldm_far_side ldm_far_side_inst (.*);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1;
    chk(nm, e, regRdData);
  endtask
  task automatic apply(input logic [2:0] f, input logic [15:0] v);
    @(posedge core_clk);
    misc = (f == 3'h5) ? v[5:0] : 6'h00;
    voltPhA <= (f == 3'h1) ? v : 16'h00e6;
    currPhA <= (f == 3'h2) ? v : 16'h0032;
    activePower <= (f == 3'h3) ? v : 16'h01f4;
    pickupRpm <= (f == 3'h4) ? v : 16'h05dc;
    rotationReversed <= misc[0];
    remoteLockPin <= misc[1];
    serviceExpired <= {misc[2], 1'b0};
    utilityOpenCmd <= misc[3];
    generatorCloseCmd <= misc[3];
    stuck <= misc[4];
    topologyFound <= ~misc[5];
    repeat (80) @(posedge core_clk);
    #1;
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rdChk("ctrl", 4'h0, 16'h02a0);
    rdChk("time", 4'h6, 16'h03e8);
    rdChk("spare", 4'hf, 16'h0000);
    for (k = 0; k < 13; k++)
      wr(k[3:0], cfg[k]);
    apply(3'h1, 16'h012c);
    rdChk("held", 4'hd, 16'h0000);
    @(posedge core_clk);
    engineRunPin <= 1'b1;
    apply(3'h1, 16'h012c);
    rdChk("armed", 4'hd, 16'h0001);
    foreach (rows[i])
    begin
      apply(3'h0, 16'h0000);
      wr(4'hd, 16'h0fff);
      apply(rows[i].f, rows[i].v);
      rdChk("flags", 4'hd, {4'h0, rows[i].e});
      chk("dump", {15'h0, |rows[i].e}, {15'h0, genBreakerOpenReq});
      chk("stop", 16'h0000, {15'h0, shutdownReq});
    end
    wr(4'h0, 16'h03d0);
    apply(3'h0, 16'h0000);
    wr(4'hd, 16'h0fff);
    apply(3'h5, 16'h0019);
    rdChk("gated", 4'hd, 16'h0000);
    apply(3'h4, 16'h0000);
    apply(3'h2, 16'h0050);
    rdChk("acts", 4'hd, 16'h0102);
    chk("warn", 16'h0001, {15'h0, warningReq});
    chk("shut", 16'h0001, {15'h0, shutdownReq});
    apply(3'h0, 16'h0000);
    wr(4'hd, 16'h0fff);
    for (k = 0; k < 8; k++)
    begin
      currPhA <= 16'h00c8;
      repeat (3) @(posedge core_clk);
      currPhA <= 16'h0032;
      repeat (5) @(posedge core_clk);
    end
    rdChk("cancel", 4'hd, 16'h0000);
    @(posedge core_clk);
    currPhA <= 16'h0190;
    repeat (7) @(posedge core_clk);
    currPhA <= 16'h0032;
    repeat (3) @(posedge core_clk);
    #1;
    chk("steep", 16'h0001, {15'h0, alarmFlags[2]});
    chk("ocStop", 16'h0001, {15'h0, shutdownReq});
    @(posedge core_clk);
    keyReq <= 1'b1;
    for (k = 0; k < 21000 && serviceCounterClear !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk("clear", 16'h0001, {15'h0, serviceCounterClear});
    chk("shown", 16'h0001, {15'h0, showCompleted});
    keyReq <= 1'b0;
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("rstFlags", 16'h0000, {4'h0, alarmFlags});
    chk("rstStop", 16'h0000, {15'h0, shutdownReq});
    rdChk("rstCtrl", 4'h0, 16'h02a0);
    completeRun();
  end
endmodule
`default_nettype wire
